// ---- rtl/mmd_pkg.sv ----
// Package of address map constants and types for the memory map decoder
package mmd_pkg;
    // -------------------------------------------------------------------------
    // Address map
    // -------------------------------------------------------------------------
    localparam logic [31:0] SDRAM_BASE = 32'h0000_0000;
    localparam logic [31:0] SDRAM_MAX_END = 32'h0800_0000;     // 128M byte ceiling
    localparam logic [31:0] SDRAM_MIN_SIZE = 32'h0100_0000;    // 16M byte floor
    localparam logic [31:0] ASYNC_BASE = 32'h2000_0000;
    localparam logic [31:0] ASYNC_BANK_SIZE = 32'h0010_0000;   // 1M byte per bank
    localparam logic [31:0] ASYNC_END = 32'h2040_0000;
    localparam logic [31:0] EXT_MAX_BYTES = 32'h0840_0000;     // 132M bytes off chip
    localparam logic [31:0] DATA_A_BASE = 32'hff80_0000;
    localparam logic [31:0] DATA_B_BASE = 32'hff90_0000;
    localparam logic [31:0] DATA_BANK_MAX = 32'h0000_8000;     // 32K byte per bank
    localparam logic [31:0] INSTR_BASE = 32'hffa0_0000;
    localparam logic [31:0] INSTR_MAX = 32'h0001_4000;         // 80K bytes
    localparam logic [31:0] INSTR_CACHE_BASE = 32'hffa1_0000;  // 16K byte cacheable part
    localparam logic [31:0] INSTR_CACHE_END = 32'hffa1_4000;
    localparam logic [31:0] SCRATCH_BASE = 32'hffb0_0000;
    localparam logic [31:0] SCRATCH_END = 32'hffb0_1000;       // 4K bytes
    localparam logic [31:0] SYS_REG_BASE = 32'hffc0_0000;
    localparam logic [31:0] CORE_REG_BASE = 32'hffe0_0000;
    localparam logic [31:0] BOOT_ROM_BASE = 32'hef00_0000;
    localparam logic [31:0] BOOT_ROM_END = 32'hef00_0800;
    localparam logic [31:0] RESET_FETCH_ADDR = 32'hffa0_0000;
    localparam int EXT_WORD_SHIFT = 1;                         // Byte line never driven

    // -------------------------------------------------------------------------
    // Targets, one-hot
    // -------------------------------------------------------------------------
    typedef enum logic [10:0] {
        TGT_NONE    = 11'h001,
        TGT_INSTR   = 11'h002,
        TGT_DATA_A  = 11'h004,
        TGT_DATA_B  = 11'h008,
        TGT_SCRATCH = 11'h010,
        TGT_CORE    = 11'h020,
        TGT_SYS     = 11'h040,
        TGT_SDRAM   = 11'h080,
        TGT_ASYNC   = 11'h100,
        TGT_BOOT    = 11'h200,
        TGT_ERR     = 11'h400
    } mmd_target_t;
endpackage : mmd_pkg

// ---- rtl/mmd_row_tracker.sv ----
// Open-row tracker for the SDRAM region: one open row per internal bank
`timescale 1ns/1ps
module mmd_row_tracker (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic access_in,
    input wire logic [1:0] bank_in,
    input wire logic [12:0] row_in,
    output logic row_hit_out,
    output logic [3:0] bank_open_out
);
    // -------------------------------------------------------------------------
    // Per-bank state
    // -------------------------------------------------------------------------
    logic [3:0] open_reg;
    logic [3:0] open_next;
    logic [12:0] row_reg [4];
    logic [12:0] row_next [4];
    logic [3:0] hit_vec;

    // One entry per bank; an access replaces whatever row was open there
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_bank
            assign hit_vec[gi] = open_reg[gi] && (row_reg[gi] == row_in);
            always_comb begin
                open_next[gi] = open_reg[gi];
                row_next[gi] = row_reg[gi];
                if (access_in && (bank_in == 2'(gi))) begin
                    open_next[gi] = 1'b1;
                    row_next[gi] = row_in;
                end
            end
            always_ff @(posedge mclk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    open_reg[gi] <= 1'b0;
                    row_reg[gi] <= 13'h0000;
                end else begin
                    open_reg[gi] <= open_next[gi];
                    row_reg[gi] <= row_next[gi];
                end
            end
        end
    endgenerate

    assign row_hit_out = hit_vec[bank_in];
    assign bank_open_out = open_reg;

    AST_ONE_ROW_PER_BANK: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        access_in |=> open_reg[$past(bank_in)] && row_reg[$past(bank_in)] == $past(row_in))
        else $error("Bank did not record the newly opened row");
endmodule : mmd_row_tracker

// ---- rtl/mmd_memory_map_decoder.sv ----
// Top of the memory map decoder: registered routing of core and DMA accesses
// Behaviour
// - Every address is 32 bits in one flat 4G space with disjoint sections.
// - Off-chip accesses go to the external bus unit, at most 132M bytes.
// - Instruction memory up to 80K; a 16K part may act as cache.
// - Data memory is up to two 32K banks, each cache or SRAM.
// - The 4K scratchpad is data SRAM only, never cache nor fetch target.
// - External bus is 16 bits; lowest address line selects 16-bit words.
// - SDRAM keeps at most one open row per bank, four banks tracked.
// - SDRAM decodes from zero, size 16M to 128M; above it reserved.
// - Four async banks each decode a fixed 1M segment from the base.
// - Core registers at the upper 2M block, system registers below it.
// - No separate I/O space; registers reached by ordinary loads and stores.
// - Register blocks only for supervisor core; DMA sees them as unmapped.
// - With boot-from-ROM, the first fetch after reset targets boot ROM if the strap has settled by then.
`timescale 1ns/1ps
module mmd_memory_map_decoder (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic req_valid_in,
    input wire logic [31:0] req_addr_in,
    input wire logic req_write_in,
    input wire logic req_fetch_in,
    input wire logic req_from_dma_in,
    input wire logic req_supervisor_in,
    input wire logic boot_from_rom_in,
    input wire logic [2:0] sdram_size_sel_in,
    input wire logic instr_cache_en_in,
    input wire logic data_a_cache_en_in,
    input wire logic data_b_cache_en_in,
    output logic [10:0] target_sel_out,
    output logic instr_sel_out,
    output logic instr_cache_hit_path_out,
    output logic data_a_sel_out,
    output logic data_b_sel_out,
    output logic data_cache_path_out,
    output logic scratch_sel_out,
    output logic core_reg_sel_out,
    output logic sys_reg_sel_out,
    output logic boot_rom_sel_out,
    output logic ext_sel_out,
    output logic sdram_sel_out,
    output logic [3:0] async_bank_sel_out,
    output logic [25:0] ext_word_addr_out,
    output logic ext_low_byte_only_out,
    output logic sdram_row_hit_out,
    output logic [3:0] sdram_bank_open_out,
    output logic [31:0] reset_fetch_addr_out,
    output logic access_error_out,
    output logic resp_valid_out
);
    // -------------------------------------------------------------------------
    // Address decode
    // -------------------------------------------------------------------------
    logic [31:0] sdram_end;
    logic in_sdram;
    logic in_sdram_hole;
    logic in_async;
    logic in_data_a;
    logic in_data_b;
    logic in_instr;
    logic in_scratch;
    logic in_sys;
    logic in_core;
    logic in_boot;
    logic reg_blocked;
    mmd_pkg::mmd_target_t tgt;
    logic boot_pending_reg;
    logic boot_pending_next;

    // Size select counts 16M steps; anything past eight steps clamps at 128M
    always_comb begin
        sdram_end = mmd_pkg::SDRAM_MIN_SIZE * (32'(sdram_size_sel_in) + 32'h1);
        if (sdram_end > mmd_pkg::SDRAM_MAX_END) begin
            sdram_end = mmd_pkg::SDRAM_MAX_END;
        end
    end

    // Full 32-bit compares: sections never overlap, so at most one is true
    assign in_sdram = req_addr_in < sdram_end;
    assign in_sdram_hole = (req_addr_in >= sdram_end) && (req_addr_in < mmd_pkg::ASYNC_BASE);
    assign in_async = (req_addr_in >= mmd_pkg::ASYNC_BASE) && (req_addr_in < mmd_pkg::ASYNC_END);
    assign in_data_a = (req_addr_in >= mmd_pkg::DATA_A_BASE)
        && (req_addr_in < mmd_pkg::DATA_A_BASE + mmd_pkg::DATA_BANK_MAX);
    assign in_data_b = (req_addr_in >= mmd_pkg::DATA_B_BASE)
        && (req_addr_in < mmd_pkg::DATA_B_BASE + mmd_pkg::DATA_BANK_MAX);
    assign in_instr = (req_addr_in >= mmd_pkg::INSTR_BASE)
        && (req_addr_in < mmd_pkg::INSTR_BASE + mmd_pkg::INSTR_MAX);
    assign in_scratch = (req_addr_in >= mmd_pkg::SCRATCH_BASE) && (req_addr_in < mmd_pkg::SCRATCH_END);
    assign in_sys = (req_addr_in >= mmd_pkg::SYS_REG_BASE) && (req_addr_in < mmd_pkg::CORE_REG_BASE);
    assign in_core = req_addr_in >= mmd_pkg::CORE_REG_BASE;
    assign in_boot = (req_addr_in >= mmd_pkg::BOOT_ROM_BASE) && (req_addr_in < mmd_pkg::BOOT_ROM_END);
    // DMA or user mode never reaches the register blocks
    assign reg_blocked = req_from_dma_in || !req_supervisor_in;

    // Target choice; registers are plain loads and stores, no I/O cycle kind
    always_comb begin
        tgt = mmd_pkg::TGT_ERR;
        if (!req_valid_in) begin
            tgt = mmd_pkg::TGT_NONE;
        end else if (in_sdram) begin
            tgt = mmd_pkg::TGT_SDRAM;
        end else if (in_async) begin
            tgt = mmd_pkg::TGT_ASYNC;
        end else if (in_instr) begin
            tgt = mmd_pkg::TGT_INSTR;
        end else if (in_data_a && !req_fetch_in) begin
            tgt = mmd_pkg::TGT_DATA_A;
        end else if (in_data_b && !req_fetch_in) begin
            tgt = mmd_pkg::TGT_DATA_B;
        end else if (in_scratch && !req_fetch_in) begin
            tgt = mmd_pkg::TGT_SCRATCH;
        end else if ((in_core || in_sys) && !reg_blocked) begin
            tgt = in_core ? mmd_pkg::TGT_CORE : mmd_pkg::TGT_SYS;
        end else if (in_boot && !req_write_in) begin
            tgt = mmd_pkg::TGT_BOOT;
        end
    end

    // -------------------------------------------------------------------------
    // Boot strap synchroniser
    // -------------------------------------------------------------------------
    logic [2:0] strap_sync_reg;
    logic [2:0] strap_sync_next;
    logic strap_reg;
    logic strap_next;

    // The strap is a pin: three stages, and a change counts once stages two and three agree
    always_comb begin
        strap_sync_next = {strap_sync_reg[1:0], boot_from_rom_in};
        strap_next = strap_reg;
        if (strap_sync_reg[1] == strap_sync_reg[2]) begin
            strap_next = strap_sync_reg[2];
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            strap_sync_reg <= 3'h0;
            strap_reg <= 1'b0;
        end else begin
            strap_sync_reg <= strap_sync_next;
            strap_reg <= strap_next;
        end
    end

    // -------------------------------------------------------------------------
    // Boot vector
    // -------------------------------------------------------------------------
    // Cleared by the first fetch; a fetch taken before the strap settles boots normally
    always_comb begin
        boot_pending_next = boot_pending_reg;
        if (req_valid_in && req_fetch_in) begin
            boot_pending_next = 1'b0;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            boot_pending_reg <= 1'b1;
        end else begin
            boot_pending_reg <= boot_pending_next;
        end
    end

    // -------------------------------------------------------------------------
    // Registered answer
    // -------------------------------------------------------------------------
    logic [10:0] tgt_reg;
    logic [10:0] tgt_next;
    logic [25:0] ext_addr_reg;
    logic [25:0] ext_addr_next;
    logic [31:0] vec_reg;
    logic [31:0] vec_next;
    logic icache_reg;
    logic icache_next;
    logic dcache_reg;
    logic dcache_next;
    logic [3:0] bank_reg;
    logic [3:0] bank_next;

    always_comb begin
        tgt_next = tgt;
        ext_addr_next = ext_addr_reg;
        bank_next = 4'h0;
        // Idle cycles show no cache path, so a stale address cannot light it
        icache_next = req_valid_in && in_instr && instr_cache_en_in && (req_addr_in >= mmd_pkg::INSTR_CACHE_BASE)
            && (req_addr_in < mmd_pkg::INSTR_CACHE_END);
        dcache_next = req_valid_in && ((in_data_a && data_a_cache_en_in) || (in_data_b && data_b_cache_en_in));
        vec_next = strap_reg ? mmd_pkg::BOOT_ROM_BASE : mmd_pkg::RESET_FETCH_ADDR;
        // First fetch after reset is forced to boot ROM when strapped
        if (req_valid_in && req_fetch_in && boot_pending_reg && strap_reg) begin
            tgt_next = mmd_pkg::TGT_BOOT;
        end
        if (tgt == mmd_pkg::TGT_SDRAM || tgt == mmd_pkg::TGT_ASYNC) begin
            // Word address only: bit 0 never leaves the chip
            ext_addr_next = req_addr_in[26:mmd_pkg::EXT_WORD_SHIFT];
        end
        if (tgt == mmd_pkg::TGT_ASYNC) begin
            bank_next = 4'h1 << req_addr_in[21:20];
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tgt_reg <= mmd_pkg::TGT_NONE;
            ext_addr_reg <= 26'h0000000;
            vec_reg <= mmd_pkg::RESET_FETCH_ADDR;
            icache_reg <= 1'b0;
            dcache_reg <= 1'b0;
            bank_reg <= 4'h0;
        end else begin
            tgt_reg <= tgt_next;
            ext_addr_reg <= ext_addr_next;
            vec_reg <= vec_next;
            icache_reg <= icache_next;
            dcache_reg <= dcache_next;
            bank_reg <= bank_next;
        end
    end

    // SDRAM open-row bookkeeping on each routed SDRAM access
    mmd_row_tracker u_rows (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .access_in(tgt == mmd_pkg::TGT_SDRAM),
        .bank_in(req_addr_in[26:25]),
        .row_in(req_addr_in[24:12]),
        .row_hit_out(sdram_row_hit_out),
        .bank_open_out(sdram_bank_open_out)
    );

    // Select outputs come straight from the registered target; async bank selects come from bank_reg
    assign target_sel_out = tgt_reg;
    assign instr_sel_out = tgt_reg[1];
    assign data_a_sel_out = tgt_reg[2];
    assign data_b_sel_out = tgt_reg[3];
    assign scratch_sel_out = tgt_reg[4];
    assign core_reg_sel_out = tgt_reg[5];
    assign sys_reg_sel_out = tgt_reg[6];
    assign sdram_sel_out = tgt_reg[7];
    assign boot_rom_sel_out = tgt_reg[9];
    assign access_error_out = tgt_reg[10];
    assign ext_sel_out = tgt_reg[7] | tgt_reg[8];
    assign async_bank_sel_out = bank_reg;
    assign ext_word_addr_out = ext_addr_reg;
    // Narrow parts use the low lane; a 16-bit bus never splits a word
    assign ext_low_byte_only_out = 1'b1;
    assign instr_cache_hit_path_out = icache_reg;
    assign data_cache_path_out = dcache_reg;
    assign reset_fetch_addr_out = vec_reg;
    assign resp_valid_out = !tgt_reg[0];

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    AST_DMA_NO_REGS: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        req_valid_in && req_from_dma_in && req_addr_in >= mmd_pkg::SYS_REG_BASE
        |=> access_error_out && !core_reg_sel_out && !sys_reg_sel_out)
        else $error("DMA reached a register block");
    AST_SCRATCH_NO_FETCH: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        req_valid_in && req_fetch_in && in_scratch |=> !scratch_sel_out)
        else $error("Fetch routed to scratchpad");
    AST_ASYNC_BANK: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        req_valid_in && in_async && !req_fetch_in |=> async_bank_sel_out == (4'h1 << $past(req_addr_in[21:20])))
        else $error("Wrong async bank");
    AST_SDRAM_HOLE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        req_valid_in && in_sdram_hole && !(req_fetch_in && boot_pending_reg && strap_reg)
        |=> access_error_out && !ext_sel_out)
        else $error("Reserved SDRAM space not refused");
    AST_WORD_ADDR: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        req_valid_in && in_sdram |=> ext_word_addr_out == $past(req_addr_in[26:1]))
        else $error("External word address wrong");
    AST_ONEHOT: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        $onehot(target_sel_out))
        else $error("Target select not one-hot");
    AST_SUP_CORE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        req_valid_in && in_core && req_supervisor_in && !req_from_dma_in && !req_fetch_in
        ##1 1'b1 |-> core_reg_sel_out && resp_valid_out)
        else $error("Core register block not selected");
    AST_BOOT_FIRST: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        req_valid_in && req_fetch_in && boot_pending_reg && strap_reg |=> boot_rom_sel_out ##1 !boot_pending_reg)
        else $error("First fetch missed boot ROM");
    COV_SDRAM: cover property (@(posedge mclk_in) disable iff (!rst_b_in) sdram_sel_out);
    COV_ERR: cover property (@(posedge mclk_in) disable iff (!rst_b_in) access_error_out);
    COV_BOOT: cover property (@(posedge mclk_in) disable iff (!rst_b_in) boot_rom_sel_out);
endmodule : mmd_memory_map_decoder

// ---- bench/mmd_requester_model.sv ----
// Requester model: a core or DMA master issuing one access at a time to the decoder
`timescale 1ns/1ps
module mmd_requester_model (
    input wire logic mclk_in,
    output logic req_valid_out,
    output logic [31:0] req_addr_out,
    output logic req_write_out,
    output logic req_fetch_out,
    output logic req_from_dma_out,
    output logic req_supervisor_out
);
    // ------------------------------------------------------------
    // Idle state
    // ------------------------------------------------------------
    initial begin
        req_valid_out = 1'b0;
        req_addr_out = 32'h0000_0000;
        {req_write_out, req_fetch_out, req_from_dma_out, req_supervisor_out} = 4'h0;
    end

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    // Kind is {write, fetch, dma, supervisor}; the decoder takes the request at the next edge
    // and the released lines show the inverse, so a stale address never passes for a live one
    task automatic issue(input logic [31:0] addr, input logic [3:0] kind);
        @(posedge mclk_in);
        #1;
        req_valid_out = 1'b1;
        req_addr_out = addr;
        {req_write_out, req_fetch_out, req_from_dma_out, req_supervisor_out} = kind;
        @(posedge mclk_in);
        #1;
        req_valid_out = 1'b0;
        req_addr_out = ~addr;
        {req_write_out, req_fetch_out, req_from_dma_out, req_supervisor_out} = ~kind;
    endtask : issue

    // Byte-wide parts sit on 16-bit word slots, so their registers are two bytes apart
    function automatic logic [31:0] byte_part_addr(input logic [31:0] base, input logic [7:0] idx);
        return base + {23'h0, idx, 1'b0};
    endfunction : byte_part_addr
endmodule : mmd_requester_model

// ---- bench/mmd_memory_map_decoder_tb.sv ----
// Self-checking testbench for the memory map decoder
`timescale 1ns/1ps
module mmd_memory_map_decoder_tb;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    localparam logic [3:0] K_LD = 4'b0001;  // Supervisor load
    localparam logic [3:0] K_USR = 4'b0000; // User load
    localparam logic [3:0] K_FE = 4'b0101;  // Supervisor fetch
    localparam logic [3:0] K_DMA = 4'b0011; // DMA, mode flag must not help
    localparam logic [3:0] K_ST = 4'b1001;  // Supervisor store
    logic mclk, rst_b, valid, wr, fetch, dma, sup, boot, ic_en, da_en, db_en;
    logic [31:0] addr, rvec;
    logic [2:0] size_sel;
    logic [10:0] tgt;
    logic icp, dcp, ext, lowb, err, resp, hit, hit_seen;
    logic [7:0] sels;
    logic [3:0] abank, bopen;
    logic [25:0] waddr;
    int err_count = 0;
    int n_tests = 0;

    mmd_requester_model req (.mclk_in(mclk), .req_valid_out(valid), .req_addr_out(addr), .req_write_out(wr),
        .req_fetch_out(fetch), .req_from_dma_out(dma), .req_supervisor_out(sup));

    mmd_memory_map_decoder dut (.mclk_in(mclk), .rst_b_in(rst_b), .req_valid_in(valid), .req_addr_in(addr),
        .req_write_in(wr), .req_fetch_in(fetch), .req_from_dma_in(dma), .req_supervisor_in(sup),
        .boot_from_rom_in(boot), .sdram_size_sel_in(size_sel), .instr_cache_en_in(ic_en),
        .data_a_cache_en_in(da_en), .data_b_cache_en_in(db_en), .target_sel_out(tgt),
        .instr_sel_out(sels[0]), .instr_cache_hit_path_out(icp), .data_a_sel_out(sels[1]),
        .data_b_sel_out(sels[2]), .data_cache_path_out(dcp), .scratch_sel_out(sels[3]),
        .core_reg_sel_out(sels[4]), .sys_reg_sel_out(sels[5]), .boot_rom_sel_out(sels[7]), .ext_sel_out(ext),
        .sdram_sel_out(sels[6]), .async_bank_sel_out(abank), .ext_word_addr_out(waddr), .ext_low_byte_only_out(lowb),
        .sdram_row_hit_out(hit), .sdram_bank_open_out(bopen), .reset_fetch_addr_out(rvec),
        .access_error_out(err), .resp_valid_out(resp));

    // Row hit is combinational on the live request, so it is caught mid-cycle
    always @(negedge mclk) hit_seen <= hit;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One access; the answer stands for exactly the cycle after the request is taken
    task automatic go(input logic [31:0] a, input logic [3:0] kind, input mmd_pkg::mmd_target_t exp);
        logic [10:0] e;
        e = exp;
        req.issue(a, kind);
        check("target", {21'h0, tgt}, {21'h0, e});
        check("selects", {24'h0, sels}, {24'h0, e[9], e[7:1]});
        check("error", {31'h0, err}, {31'h0, e[10]});
        check("resp", {31'h0, resp}, 32'h1);
        check("ext sel", {31'h0, ext}, {31'h0, e[7] | e[8]});
    endtask : go

    task automatic do_reset();
        rst_b = 1'b0;
        repeat (16) @(posedge mclk);
        #1;
        rst_b = 1'b1;
    endtask : do_reset

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic sc_reset_values();
        check("target", {21'h0, tgt}, 32'h001);
        check("resp", {31'h0, resp}, 32'h0);
        check("vector", rvec, mmd_pkg::RESET_FETCH_ADDR);
        check("low byte", {31'h0, lowb}, 32'h1);
        check("word addr", {6'h0, waddr}, 32'h0);
    endtask : sc_reset_values

    // Bank field is addr[26:25]; a new row in an open bank must not open a second entry
    task automatic sc_open_rows();
        go(32'h0000_1000, K_LD, mmd_pkg::TGT_SDRAM);
        check("banks", {28'h0, bopen}, 32'h1);
        check("row hit", {31'h0, hit_seen}, 32'h0);
        go(32'h0600_2000, K_DMA, mmd_pkg::TGT_SDRAM);
        go(32'h0000_3000, K_ST, mmd_pkg::TGT_SDRAM);
        check("row hit", {31'h0, hit_seen}, 32'h0);
        check("banks", {28'h0, bopen}, 32'h9);
        go(32'h0000_3ffc, K_LD, mmd_pkg::TGT_SDRAM);
        check("row hit", {31'h0, hit_seen}, 32'h1);
    endtask : sc_open_rows

    task automatic sc_sdram_size();
        size_sel = 3'h0;
        go(32'h00ff_fffe, K_LD, mmd_pkg::TGT_SDRAM);
        check("word addr", {6'h0, waddr}, 32'h007f_ffff);
        go(32'h0100_0000, K_LD, mmd_pkg::TGT_ERR);
        check("word addr", {6'h0, waddr}, 32'h007f_ffff);
        size_sel = 3'h7;
        go(32'h07ff_fffe, K_ST, mmd_pkg::TGT_SDRAM);
        go(32'h0800_0000, K_LD, mmd_pkg::TGT_ERR);
        go(32'h1fff_fffc, K_LD, mmd_pkg::TGT_ERR);
    endtask : sc_sdram_size

    task automatic sc_async_banks();
        for (int b = 0; b < 4; b++) begin
            go(mmd_pkg::ASYNC_BASE + 32'(b) * mmd_pkg::ASYNC_BANK_SIZE + 32'h4, K_LD, mmd_pkg::TGT_ASYNC);
            check("bank", {28'h0, abank}, 32'h1 << b);
        end
        go(32'h2010_0004, K_LD, mmd_pkg::TGT_ASYNC);
        check("word addr", {6'h0, waddr}, 32'h0008_0002);
        go(mmd_pkg::ASYNC_END, K_LD, mmd_pkg::TGT_ERR);
        go(req.byte_part_addr(mmd_pkg::ASYNC_BASE, 8'h3), K_ST, mmd_pkg::TGT_ASYNC);
        check("word addr", {6'h0, waddr}, 32'h0000_0003);
    endtask : sc_async_banks

    task automatic sc_internal();
        go(mmd_pkg::INSTR_BASE, K_FE, mmd_pkg::TGT_INSTR);
        go(32'hffa1_3ffc, K_FE, mmd_pkg::TGT_INSTR);
        go(32'hffa1_4000, K_FE, mmd_pkg::TGT_ERR);
        go(mmd_pkg::DATA_A_BASE, K_LD, mmd_pkg::TGT_DATA_A);
        go(32'hff90_7ffc, K_ST, mmd_pkg::TGT_DATA_B);
        go(32'hff90_8000, K_LD, mmd_pkg::TGT_ERR);
        go(mmd_pkg::DATA_A_BASE, K_FE, mmd_pkg::TGT_ERR);
        go(32'hffb0_0ffc, K_LD, mmd_pkg::TGT_SCRATCH);
        go(mmd_pkg::SCRATCH_BASE, K_FE, mmd_pkg::TGT_ERR);
        go(mmd_pkg::SCRATCH_END, K_LD, mmd_pkg::TGT_ERR);
    endtask : sc_internal

    task automatic sc_cache_paths();
        ic_en = 1'b1;
        da_en = 1'b1;
        go(mmd_pkg::INSTR_CACHE_BASE, K_FE, mmd_pkg::TGT_INSTR);
        check("icache", {31'h0, icp}, 32'h1);
        go(mmd_pkg::INSTR_BASE, K_FE, mmd_pkg::TGT_INSTR);
        check("icache", {31'h0, icp}, 32'h0);
        go(mmd_pkg::DATA_A_BASE, K_LD, mmd_pkg::TGT_DATA_A);
        check("dcache", {31'h0, dcp}, 32'h1);
        go(mmd_pkg::DATA_B_BASE, K_LD, mmd_pkg::TGT_DATA_B);
        check("dcache", {31'h0, dcp}, 32'h0);
        db_en = 1'b1;
        go(mmd_pkg::DATA_B_BASE, K_LD, mmd_pkg::TGT_DATA_B);
        check("dcache", {31'h0, dcp}, 32'h1);
        // Every cache enable on, and still the scratchpad is never a cache path
        go(mmd_pkg::SCRATCH_BASE, K_LD, mmd_pkg::TGT_SCRATCH);
        check("dcache", {31'h0, dcp}, 32'h0);
        ic_en = 1'b0;
        da_en = 1'b0;
        db_en = 1'b0;
    endtask : sc_cache_paths

    task automatic sc_registers();
        go(mmd_pkg::CORE_REG_BASE, K_LD, mmd_pkg::TGT_CORE);
        go(32'hffff_fffc, K_ST, mmd_pkg::TGT_CORE);
        go(mmd_pkg::SYS_REG_BASE, K_ST, mmd_pkg::TGT_SYS);
        go(32'hffdf_fffc, K_LD, mmd_pkg::TGT_SYS);
        go(mmd_pkg::SYS_REG_BASE, K_USR, mmd_pkg::TGT_ERR);
        go(mmd_pkg::CORE_REG_BASE, K_DMA, mmd_pkg::TGT_ERR);
        go(32'hffbf_fffc, K_LD, mmd_pkg::TGT_ERR);
    endtask : sc_registers

    // Strap set before a second reset, as a board would hold it; the strap needs four edges to settle
    task automatic sc_boot_rom();
        boot = 1'b1;
        do_reset();
        repeat (4) @(posedge mclk);
        go(mmd_pkg::INSTR_BASE, K_FE, mmd_pkg::TGT_BOOT);
        check("vector", rvec, mmd_pkg::BOOT_ROM_BASE);
        go(mmd_pkg::INSTR_BASE, K_FE, mmd_pkg::TGT_INSTR);
        go(mmd_pkg::BOOT_ROM_BASE, K_ST, mmd_pkg::TGT_ERR);
        go(32'hef00_07fc, K_FE, mmd_pkg::TGT_BOOT);
    endtask : sc_boot_rom

    // ------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Bounds the whole run so a stuck scenario still reaches the verdict
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        wrap_up();
    end

    initial begin
        rst_b = 1'b0;
        boot = 1'b0;
        size_sel = 3'h7;
        ic_en = 1'b0;
        da_en = 1'b0;
        db_en = 1'b0;
        do_reset();
        sc_reset_values();
        sc_open_rows();
        sc_sdram_size();
        sc_async_banks();
        sc_internal();
        sc_cache_paths();
        sc_registers();
        sc_boot_rom();
        wrap_up();
    end
endmodule : mmd_memory_map_decoder_tb
